// *** core/bridge_pwm_pkg.sv ***
// Constants shared by the bridge PWM output stage and its register slave.
// Assumes register indices are word indices: byte address is four times the index.
package bridge_pwm_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [14:0] IDX_OUT = 15'h00f8;
    localparam logic [14:0] IDX_DUTY = 15'h4058;
    localparam logic [14:0] IDX_CMP = 15'h405a;
    localparam logic [14:0] IDX_CHAN = 15'h405c;
    localparam logic [14:0] IDX_PERIOD = 15'h405e;
    localparam logic [14:0] IDX_DT = 15'h4060;
    localparam logic [14:0] IDX_STAT = 15'h4061;
    localparam logic [14:0] IDX_CTRL = 15'h4062;
    localparam logic [14:0] IDX_CNT = 15'h4066;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MOE_BIT = 7;
    localparam int RUN_BIT = 7;
    localparam int PRELOAD_BIT = 4;
    localparam int SRC_BIT = 3;
    localparam int FLAG_BIT = 4;
    // Phase order U, V, W, X
    localparam int HE_BIT [4] = '{1, 3, 5, 13};
    localparam int LE_BIT [4] = '{0, 2, 4, 12};
    localparam int HP_BIT [4] = '{7, 9, 11, 15};
    localparam int LP_BIT [4] = '{6, 8, 10, 14};
    // X shares the W idle levels
    localparam int IDLE_H_BIT [4] = '{0, 2, 4, 4};
    localparam int IDLE_L_BIT [4] = '{1, 3, 5, 5};

    // ------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OUT_MASK = 8'hbf;
    localparam logic [7:0] CTRL_MASK = 8'h98;
    localparam logic [15:0] DUTY_MASK = 16'h3fff;
    localparam logic [15:0] PERIOD_MASK = 16'h3ffe;
    localparam logic [15:0] CMP_MASK = 16'h0fff;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DT_RST = 8'h00;
    localparam logic [1:0] STAT_MODE_RST = 2'h0;
    localparam logic [15:0] WORD16_RST = 16'h0000;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MATCH_NEVER = 2'h0,
        MATCH_UP = 2'h1,
        MATCH_DOWN = 2'h2,
        MATCH_BOTH = 2'h3
    } match_mode_t;

    typedef enum logic [1:0] {
        CNT_UP = 2'h1,
        CNT_DOWN = 2'h2
    } cnt_dir_t;

endpackage

// *** core/deadtime_gen.sv ***
// Deadtime generator for one phase: splits a reference into a leading and a
// complementary drive, both held off for (dead + 1) clocks after each edge when dead is nonzero.
// Assumes dead is a static register value and lead is on the same clock.
`timescale 1ns/100ps
module deadtime_gen (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Reference and setting
    input wire logic lead,
    input wire logic [7:0] dead,
    // Drives
    output logic lead_out,
    output logic comp_out
);
    logic lead_d;
    logic [7:0] wait_cnt;
    logic quiet;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lead_d <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else
        begin
            lead_d <= lead;
            if (lead != lead_d)
                wait_cnt <= dead;
            else if (wait_cnt != 8'h00)
                wait_cnt <= wait_cnt - 8'h01;
        end
    end

    // Edge cycle plus dead counted cycles both sides off; zero bypasses
    assign quiet = (dead != 8'h00) && ((lead != lead_d) || (wait_cnt != 8'h00));
    assign lead_out = lead & ~quiet;
    assign comp_out = ~lead & ~quiet;

endmodule // deadtime_gen

// *** core/bridge_pwm.sv ***
// Output stage of a three-phase bridge PWM with AXI4-Lite register slave.
// Assumes field-oriented compare values and commutation writes are on aclk;
// the bus-current fault arrives asynchronously.
`timescale 1ns/100ps

module bridge_pwm (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [16:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [16:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Field-oriented compare values
    input wire logic [13:0] foc_cmp_u,
    input wire logic [13:0] foc_cmp_v,
    input wire logic [13:0] foc_cmp_w,
    // Commutation timer
    input wire logic comm_write,
    input wire logic [15:0] comm_data,
    // Protection pin
    input wire logic bus_fault,
    // Gate drives, index U, V, W, X
    output logic [3:0] gate_high,
    output logic [3:0] gate_low
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [14:0] aw_idx;
    logic [31:0] wd;
    logic [3:0] ws;
    logic do_write;
    logic [15:0] wr_word;
    logic [7:0] hi_shadow;
    logic [31:0] rd_word;
    logic [7:0] output_enable_idle_levels;
    logic [7:0] control;
    logic [1:0] match_irq_mode;
    logic match_irq_flag;
    logic [15:0] channel_enable_polarity;
    logic [15:0] carrier_period;
    logic [15:0] compare_match_value;
    logic [15:0] duty_written;
    logic [13:0] duty_active;
    logic [7:0] deadtime_setting;
    logic [13:0] cnt;
    typedef bridge_pwm_pkg::cnt_dir_t cnt_dir_local_t;
    cnt_dir_local_t dir;
    logic fault_meta;
    logic fault_sync;
    logic counter_run;
    logic duty_preload_on;
    logic src_foc;
    logic main_output_on;
    logic [12:0] half;
    logic [12:0] top;
    logic overflow;
    logic underflow;
    logic match_hit;
    logic [3:0] next_gate_high;
    logic [3:0] next_gate_low;
    logic [13:0] cmp_src [4];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [14:0] idx);
        return (idx == bridge_pwm_pkg::IDX_OUT) || (idx == bridge_pwm_pkg::IDX_DUTY)
            || (idx == bridge_pwm_pkg::IDX_CMP) || (idx == bridge_pwm_pkg::IDX_CHAN)
            || (idx == bridge_pwm_pkg::IDX_PERIOD) || (idx == bridge_pwm_pkg::IDX_DT)
            || (idx == bridge_pwm_pkg::IDX_STAT) || (idx == bridge_pwm_pkg::IDX_CTRL)
            || (idx == bridge_pwm_pkg::IDX_CNT);
    endfunction

    function automatic logic commit(input logic [14:0] idx);
        return do_write && (aw_idx == idx) && ws[0];
    endfunction

    // Half of a compare value in fine units against the half-rate counter
    function automatic logic below(input logic [13:0] c, input logic [13:0] v);
        return c < {1'b0, v[13:1]};
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_word = {ws[1] ? wd[15:8] : hi_shadow, wd[7:0]};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 15'h0000;
            wd <= 32'h0000_0000;
            ws <= 4'h0;
            bvalid <= 1'b0;
            bresp <= bridge_pwm_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_idx <= awaddr[16:2];
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                wd <= wdata;
                ws <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= is_mapped(aw_idx) ? bridge_pwm_pkg::RESP_OKAY
                                           : bridge_pwm_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // High byte waits here until its low byte arrives
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hi_shadow <= 8'h00;
        else if (do_write && ws[1] && !ws[0])
            hi_shadow <= wd[15:8];
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (araddr[16:2])
            bridge_pwm_pkg::IDX_OUT: rd_word[7:0] = output_enable_idle_levels;
            bridge_pwm_pkg::IDX_DUTY: rd_word[15:0] = duty_written;
            bridge_pwm_pkg::IDX_CMP: rd_word[15:0] = compare_match_value;
            bridge_pwm_pkg::IDX_CHAN: rd_word[15:0] = channel_enable_polarity;
            bridge_pwm_pkg::IDX_PERIOD: rd_word[15:0] = carrier_period;
            bridge_pwm_pkg::IDX_DT: rd_word[7:0] = deadtime_setting;
            bridge_pwm_pkg::IDX_STAT: rd_word[7:0] = {3'h0, match_irq_flag, 2'h0, match_irq_mode};
            bridge_pwm_pkg::IDX_CTRL: rd_word[7:0] = control;
            bridge_pwm_pkg::IDX_CNT: rd_word[11:0] = cnt[13:2];
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= bridge_pwm_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= is_mapped(araddr[16:2]) ? bridge_pwm_pkg::RESP_OKAY
                                             : bridge_pwm_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_meta <= 1'b0;
            fault_sync <= 1'b0;
        end
        else
        begin
            fault_meta <= bus_fault;
            fault_sync <= fault_meta;
        end
    end

    // Fault beats a software set in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            output_enable_idle_levels <= bridge_pwm_pkg::OUT_RST;
        else
        begin
            if (commit(bridge_pwm_pkg::IDX_OUT))
                output_enable_idle_levels <= wd[7:0] & bridge_pwm_pkg::OUT_MASK;
            if (fault_sync)
                output_enable_idle_levels[bridge_pwm_pkg::MOE_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            control <= bridge_pwm_pkg::CTRL_RST;
        else if (commit(bridge_pwm_pkg::IDX_CTRL))
            control <= wd[7:0] & bridge_pwm_pkg::CTRL_MASK;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            channel_enable_polarity <= bridge_pwm_pkg::WORD16_RST;
        else if (comm_write)
            channel_enable_polarity <= comm_data;
        else if (commit(bridge_pwm_pkg::IDX_CHAN))
            channel_enable_polarity <= wr_word;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            carrier_period <= bridge_pwm_pkg::WORD16_RST;
            compare_match_value <= bridge_pwm_pkg::WORD16_RST;
            deadtime_setting <= bridge_pwm_pkg::DT_RST;
        end
        else
        begin
            if (commit(bridge_pwm_pkg::IDX_PERIOD))
                carrier_period <= wr_word & bridge_pwm_pkg::PERIOD_MASK;
            if (commit(bridge_pwm_pkg::IDX_CMP))
                compare_match_value <= wr_word & bridge_pwm_pkg::CMP_MASK;
            if (commit(bridge_pwm_pkg::IDX_DT))
                deadtime_setting <= wd[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            duty_written <= bridge_pwm_pkg::WORD16_RST;
            duty_active <= 14'h0000;
        end
        else
        begin
            if (commit(bridge_pwm_pkg::IDX_DUTY))
            begin
                duty_written <= wr_word & bridge_pwm_pkg::DUTY_MASK;
                if (!duty_preload_on)
                    duty_active <= wr_word[13:0];
            end
            else if (duty_preload_on && underflow)
                duty_active <= duty_written[13:0];
        end
    end

    // Hardware set wins over a clearing write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            match_irq_mode <= bridge_pwm_pkg::STAT_MODE_RST;
            match_irq_flag <= 1'b0;
        end
        else
        begin
            if (commit(bridge_pwm_pkg::IDX_STAT))
            begin
                match_irq_mode <= wd[1:0];
                if (!wd[bridge_pwm_pkg::FLAG_BIT])
                    match_irq_flag <= 1'b0;
            end
            if (match_hit)
                match_irq_flag <= 1'b1;
        end
    end

    assign main_output_on = output_enable_idle_levels[bridge_pwm_pkg::MOE_BIT];
    assign counter_run = control[bridge_pwm_pkg::RUN_BIT];
    assign duty_preload_on = control[bridge_pwm_pkg::PRELOAD_BIT];
    assign src_foc = control[bridge_pwm_pkg::SRC_BIT];

    // ------------------------------------------------------------
    // Carrier counter
    // ------------------------------------------------------------
    assign half = carrier_period[13:1];
    assign top = half - 13'h0001;
    assign overflow = counter_run && (half != 13'h0000) && (dir == bridge_pwm_pkg::CNT_UP)
                      && (cnt >= {1'b0, top});
    assign underflow = counter_run && (dir == bridge_pwm_pkg::CNT_DOWN) && (cnt == 14'h0000);
    assign match_hit = counter_run && (cnt[13:2] == compare_match_value[11:0])
                       && (cnt[1:0] == 2'h0)
                       && (((dir == bridge_pwm_pkg::CNT_UP) && match_irq_mode[0])
                       || ((dir == bridge_pwm_pkg::CNT_DOWN) && match_irq_mode[1]));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 14'h0000;
            dir <= bridge_pwm_pkg::CNT_UP;
        end
        else if (counter_run && commit(bridge_pwm_pkg::IDX_CNT))
            cnt <= {wr_word[11:0], 2'h0};
        else if (counter_run)
        begin
            unique case (dir)
                bridge_pwm_pkg::CNT_UP:
                begin
                    if (half == 13'h0000)
                        cnt <= 14'h0000;
                    else if (overflow)
                    begin
                        // Top is held one cycle, like zero, so a period is carrier_period clocks
                        dir <= bridge_pwm_pkg::CNT_DOWN;
                    end
                    else
                        cnt <= cnt + 14'h0001;
                end
                bridge_pwm_pkg::CNT_DOWN:
                begin
                    if (underflow)
                        dir <= bridge_pwm_pkg::CNT_UP;
                    else
                        cnt <= cnt - 14'h0001;
                end
                default: dir <= bridge_pwm_pkg::CNT_UP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Phase outputs
    // ------------------------------------------------------------
    assign cmp_src[0] = src_foc ? foc_cmp_u : duty_active;
    assign cmp_src[1] = src_foc ? foc_cmp_v : duty_active;
    assign cmp_src[2] = src_foc ? foc_cmp_w : duty_active;
    assign cmp_src[3] = cmp_src[2];

    for (genvar p = 0; p < 4; p++)
    begin : g_phase
        logic ref_on;
        logic dt_lead;
        logic dt_comp;
        logic en_h;
        logic en_l;
        logic pwm_h;
        logic pwm_l;
        logic gh;
        logic gl;

        assign ref_on = below(cnt, cmp_src[p]);
        assign next_gate_high[p] = gh;
        assign next_gate_low[p] = gl;
        assign en_h = channel_enable_polarity[bridge_pwm_pkg::HE_BIT[p]];
        assign en_l = channel_enable_polarity[bridge_pwm_pkg::LE_BIT[p]];

        deadtime_gen u_dead (
            .aclk(aclk),
            .aresetn(aresetn),
            .lead(ref_on),
            .dead(deadtime_setting),
            .lead_out(dt_lead),
            .comp_out(dt_comp)
        );

        // Software source leads on the high side, field-oriented on the low side
        always_comb
        begin
            if (en_h && en_l)
            begin
                pwm_h = src_foc ? dt_comp : dt_lead;
                pwm_l = src_foc ? dt_lead : dt_comp;
            end
            else
            begin
                pwm_h = en_h & ref_on;
                pwm_l = en_l & ~ref_on;
            end
            if (main_output_on)
            begin
                gh = pwm_h ^ channel_enable_polarity[bridge_pwm_pkg::HP_BIT[p]];
                gl = pwm_l ^ channel_enable_polarity[bridge_pwm_pkg::LP_BIT[p]];
            end
            else
            begin
                gh = output_enable_idle_levels[bridge_pwm_pkg::IDLE_H_BIT[p]];
                gl = output_enable_idle_levels[bridge_pwm_pkg::IDLE_L_BIT[p]];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gate_high <= 4'h0;
            gate_low <= 4'h0;
        end
        else
        begin
            gate_high <= next_gate_high;
            gate_low <= next_gate_low;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_IDLE_U: assert property (!main_output_on |=> gate_high[0] == $past(output_enable_idle_levels[0]))
        else $error("U high not at idle level");
    AST_FAULT: assert property (fault_sync |=> !main_output_on ##1 gate_low[1] == $past(output_enable_idle_levels[3]))
        else $error("fault did not force idle");
    AST_IDLE_X: assert property (!main_output_on |=> gate_low[3] == $past(output_enable_idle_levels[5]))
        else $error("X low not following W idle level");
    AST_PERIOD_LSB: assert property (carrier_period[0] == 1'b0)
        else $error("period bit 0 set");
    AST_OVF_TURN: assert property (overflow && !commit(bridge_pwm_pkg::IDX_CNT) |=> dir == bridge_pwm_pkg::CNT_DOWN)
        else $error("counter did not turn at top");
    AST_STOPPED: assert property (!counter_run |=> $stable(cnt))
        else $error("counter moved while stopped");
    AST_FLAG_SET: assert property (match_hit |=> match_irq_flag)
        else $error("match flag not set");
    AST_MODE_NEVER: assert property ((match_irq_mode == 2'h0) |-> !match_hit)
        else $error("match raised with mode never");
    AST_PRELOAD: assert property (duty_preload_on && !underflow |=> $stable(duty_active))
        else $error("duty changed before underflow");

endmodule // bridge_pwm

// *** test/gate_driver_model.sv ***
// Gate driver model: turns each phase's gate pair into a conduct state.
// Assumes active-high drives sampled on aclk.
`timescale 1ns/100ps
module gate_driver_model (
    // Clock
    input wire logic aclk,
    // Gate drives, index U, V, W, X
    input wire logic [3:0] gate_high,
    input wire logic [3:0] gate_low,
    // High side conducts alone
    output logic [3:0] phase_on
);
    always_ff @(posedge aclk)
        phase_on <= gate_high & ~gate_low;
endmodule // gate_driver_model

// *** test/three_phase_bridge_pwm_output_test.sv ***
// Bench for bridge_pwm: registers over AXI4-Lite, gate levels at the pins.
// Assumes bridge_pwm_pkg and the gate driver model are compiled first.
`timescale 1ns/100ps
module three_phase_bridge_pwm_output_test;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, comm_write = 0, bus_fault = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [16:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd_val, v, rs = 32'd21;
    logic [3:0] wstrb = 0, gate_high, gate_low, phase_on;
    logic [1:0] bresp, rresp, rr;
    logic [13:0] foc_cmp_u = 0, foc_cmp_v = 0, foc_cmp_w = 0;
    logic [15:0] comm_data = 0;
    int n_fail = 0, samples_checked = 0, f = 0;
    always #50 aclk = ~aclk;
    bridge_pwm uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .foc_cmp_u(foc_cmp_u), .foc_cmp_v(foc_cmp_v), .foc_cmp_w(foc_cmp_w),
        .comm_write(comm_write), .comm_data(comm_data), .bus_fault(bus_fault),
        .gate_high(gate_high), .gate_low(gate_low));
    gate_driver_model drv (.aclk(aclk), .gate_high(gate_high), .gate_low(gate_low),
        .phase_on(phase_on));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // Gates expected while main output is off; X shares W's idle bits
    function automatic logic [31:0] idle_gates(input logic [5:0] l);
        return {24'h0, l[5], l[5], l[3], l[1], l[4], l[4], l[2], l[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // U conduct and low-side cycles over one 64-clock carrier period, after settling
    task automatic meas(input int hi_exp, input int lo_exp);
        int hi = 0, lo = 0;
        repeat (130) @(posedge aclk);
        repeat (64)
        begin
            @(posedge aclk);
            hi += phase_on[0];
            lo += gate_low[0];
        end
        chk(hi, hi_exp);
        chk(lo, lo_exp);
    endtask
    task automatic wr(input logic [14:0] i, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        while (bvalid !== 1'b1);
        bready <= 0;
    endtask
    task automatic rd(input logic [14:0] i);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        while (rvalid !== 1'b1);
        rd_val = rdata;
        rr = rresp;
        rready <= 0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        foc_cmp_u <= 14'(rnd());
        rd(bridge_pwm_pkg::IDX_CHAN);
        chk(rd_val, 0);
        wr(bridge_pwm_pkg::IDX_PERIOD, 32'hffff_ffff);
        rd(bridge_pwm_pkg::IDX_PERIOD);
        chk(rd_val, 32'h0000_3ffe);
        wr(bridge_pwm_pkg::IDX_OUT, 32'hffff_ffff);
        rd(bridge_pwm_pkg::IDX_OUT);
        chk(rd_val, 32'h0000_00bf);
        rd(15'h0001);
        chk(32'(rr), 32'(bridge_pwm_pkg::RESP_SLVERR));
        repeat (4)
        begin
            v = rnd();
            wr(bridge_pwm_pkg::IDX_OUT, {26'h0, v[5:0]});
            repeat (3) @(posedge aclk);
            chk(32'({gate_low, gate_high}), idle_gates(v[5:0]));
        end
        $display("idle levels done");
        wr(bridge_pwm_pkg::IDX_DUTY, 0);
        wr(bridge_pwm_pkg::IDX_OUT, 32'h0000_0080);
        wr(bridge_pwm_pkg::IDX_CHAN, 32'h0000_0002);
        repeat (3) @(posedge aclk);
        chk(32'(gate_high[0]), 0);
        wr(bridge_pwm_pkg::IDX_CHAN, 32'h0000_0082);
        repeat (3) @(posedge aclk);
        chk(32'(gate_high[0]), 1);
        bus_fault <= 1;
        repeat (6) @(posedge aclk);
        chk(32'({gate_low, gate_high}), 0);
        rd(bridge_pwm_pkg::IDX_OUT);
        chk(rd_val, 0);
        bus_fault <= 0;
        $display("polarity and fault done");
        v = rnd();
        comm_data <= v[15:0];
        comm_write <= 1;
        @(posedge aclk);
        comm_write <= 0;
        rd(bridge_pwm_pkg::IDX_CHAN);
        chk(rd_val, {16'h0, v[15:0]});
        wr(bridge_pwm_pkg::IDX_CNT, 32'h0000_0123);
        rd(bridge_pwm_pkg::IDX_CNT);
        chk(rd_val, 0);
        wr(bridge_pwm_pkg::IDX_PERIOD, 32'h0000_0040);
        wr(bridge_pwm_pkg::IDX_CMP, 32'h0000_0004);
        wr(bridge_pwm_pkg::IDX_STAT, 32'h0000_0003);
        wr(bridge_pwm_pkg::IDX_CTRL, 32'h0000_0080);
        repeat (80) @(posedge aclk);
        rd(bridge_pwm_pkg::IDX_STAT);
        chk(rd_val, 32'h0000_0013);
        wr(bridge_pwm_pkg::IDX_STAT, 32'h0000_0010);
        rd(bridge_pwm_pkg::IDX_STAT);
        chk(rd_val, 32'h0000_0010);
        wr(bridge_pwm_pkg::IDX_STAT, 0);
        repeat (80) @(posedge aclk);
        rd(bridge_pwm_pkg::IDX_STAT);
        chk(rd_val, 0);
        $display("match flag done");
        wr(bridge_pwm_pkg::IDX_CNT, 32'h0000_000f);
        wr(bridge_pwm_pkg::IDX_CTRL, 0);
        rd(bridge_pwm_pkg::IDX_CNT);
        chk(rd_val, 32'h0000_000e);
        wr(bridge_pwm_pkg::IDX_OUT, 32'h0000_0080);
        wr(bridge_pwm_pkg::IDX_CHAN, 32'h0000_0003);
        wr(bridge_pwm_pkg::IDX_DT, 32'h0000_0003);
        wr(bridge_pwm_pkg::IDX_CTRL, 32'h0000_0090);
        wr(bridge_pwm_pkg::IDX_DUTY, 32'h0000_0014);
        meas(16, 40);
        wr(bridge_pwm_pkg::IDX_DT, 0);
        wr(bridge_pwm_pkg::IDX_CTRL, 32'h0000_0080);
        meas(20, 44);
        v = rnd();
        f = 8 + int'(v % 48);
        foc_cmp_u <= 14'(f);
        wr(bridge_pwm_pkg::IDX_DT, 32'h0000_0003);
        wr(bridge_pwm_pkg::IDX_CTRL, 32'h0000_0088);
        meas(60 - (f & ~1), (f & ~1) - 4);
        $display("deadtime done");
        summarize();
    end
endmodule // three_phase_bridge_pwm_output_test
